// ==== test/lhb_host_model.sv ====
/*
 * lhb_host_model: host microcontroller at the far side of the port.
 * Assumes mode_i is set before each reset: 0 8080, 1 6800, 2 serial.
 */
`timescale 1ns/1ps
module lhb_host_model (
	// link clock and setup
	input  wire logic        clk_link_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic [1:0]  hi_straps_i,
	input  wire logic [15:0] dev_data_i,
	// host pins
	output logic             cs_n_o,
	output logic             cd_o,
	output logic             hi_o,
	output logic             lo_o,
	output logic [15:0]      data_o
);
	initial begin
		cs_n_o = 1'b1;
		cd_o = 1'b0;
		hi_o = 1'b0;
		lo_o = 1'b0;
		data_o = 16'h0;
	end

	// ---------------------------------------------------------------
	// idle levels, strap lines on 15 and 13
	// ---------------------------------------------------------------
	task automatic idle();
		@(posedge clk_link_i);
		cs_n_o <= 1'b1;
		cd_o   <= 1'b0;
		hi_o   <= (mode_i == 2'd0); // serial ties both low
		lo_o   <= (mode_i == 2'd0);
		data_o <= {hi_straps_i[1], 1'b0, hi_straps_i[0], 13'h0};
	endtask

	// ---------------------------------------------------------------
	// parallel cycle, strobe 6 link cycles wide
	// ---------------------------------------------------------------
	task automatic par(input logic rd, input logic cd, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clk_link_i);
		cs_n_o <= 1'b0;
		cd_o   <= cd;
		lo_o   <= (mode_i == 2'd1) ? rd : lo_o;
		data_o <= rd ? ~data_o : d;
		@(posedge clk_link_i);
		hi_o <= (mode_i == 2'd1) | ~rd; // e high, or read strobe low
		lo_o <= rd; // direction, or write strobe low
		repeat (6) @(posedge clk_link_i);
		q = dev_data_i;
		hi_o <= (mode_i == 2'd0);
		lo_o <= (mode_i == 2'd0);
		// device needs 3 edges to release the bus after a read
		repeat (4) @(posedge clk_link_i);
		cs_n_o <= 1'b1;
		data_o <= ~data_o;
		// spacing covers the word hand-over to the system side
		repeat (40) @(posedge clk_link_i);
	endtask

	// ---------------------------------------------------------------
	// serial token, msb first, sck stands still outside frames
	// ---------------------------------------------------------------
	task automatic ser(input int n, input logic [8:0] v, input logic cd);
		@(posedge clk_link_i);
		cs_n_o    <= 1'b0;
		cd_o      <= cd; // s9 keeps it low
		data_o[0] <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk_link_i);
			data_o[0] <= 1'b0; // sck on line 0
			data_o[8] <= v[i]; // sda on line 8
			repeat (2) @(posedge clk_link_i);
			data_o[0] <= 1'b1;
			repeat (2) @(posedge clk_link_i);
		end
		data_o[0] <= 1'b0;
		repeat (3) @(posedge clk_link_i);
		cs_n_o    <= 1'b1;
		data_o[8] <= ~data_o[8];
		repeat (40) @(posedge clk_link_i);
	endtask
endmodule

// ==== test/lhb_host_port_tb.sv ====
/*
 * lhb_host_port_tb: self-checking bench of the host bus port.
 * Assumes the host model drives the pins; axi master lives here.
 */
`timescale 1ns/1ps
module lhb_host_port_tb;
	logic        clk_sys = 1'b0;
	logic        clk_link = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  awaddr = 8'h0;
	logic [7:0]  araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [1:0]  bm = 2'h0;
	logic [1:0]  hs = 2'h0;
	logic [1:0]  hmode = 2'h0;
	logic        lane = 1'b0;
	logic        prod = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, oe_n, cs_n, cd, hi, lo;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [1:0]  wresp = 2'h0;
	logic [15:0] dev_d, host_d, pins;
	int          n_mismatch = 0;
	int          num_checks = 0;

	always #25 clk_sys = ~clk_sys;
	always #3 clk_link = ~clk_link;
	assign pins = oe_n ? host_d : dev_d;

	lhb_host_port dut (.clk_sys_i(clk_sys), .clk_link_i(clk_link), .arst_n_i(arst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bus_mode_straps_i(bm),
		.byte_lane_strap_i(lane), .production_strap_i(prod), .chip_select_n_i(cs_n),
		.cmd_data_select_i(cd), .rw_ctrl_hi_i(hi), .rw_ctrl_lo_i(lo),
		.data_line_i(pins), .data_line_o(dev_d), .data_line_oe_n_o(oe_n));

	lhb_host_model host (.clk_link_i(clk_link), .mode_i(hmode), .hi_straps_i(hs),
		.dev_data_i(pins), .cs_n_o(cs_n), .cd_o(cd), .hi_o(hi), .lo_o(lo), .data_o(host_d));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rst(input logic [1:0] b, input logic [1:0] s, input logic ln,
		input logic pr);
		@(posedge clk_sys);
		arst_n <= 1'b0; // held 12 cycles only, shorter than the part needs
		bm     <= b;
		hs     <= s;
		lane   <= ln;
		prod   <= pr;
		hmode  <= s[1] ? 2'd2 : {1'b0, b[0]};
		host.idle();
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		// wait shortened from the real part's settle time
		repeat (4) @(posedge clk_sys);
	endtask

	// registered readies are stable from the falling edge to the next rise
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int   k;
		logic ta, tw, tb;
		@(posedge clk_sys);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge clk_sys);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			wresp = bresp;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		if (k == 50) begin
			n_mismatch++;
			close_out();
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int   k;
		logic ta, tr;
		@(posedge clk_sys);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge clk_sys);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (k == 50) begin
			n_mismatch++;
			close_out();
		end
	endtask

	task automatic get_rx(input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0]  r;
		for (int k = 0; k < 30; k++) begin
			axi_rd(lhb_pkg::OFS_STAT, v, r);
			if (v[lhb_pkg::STAT_RXV] === 1'b1) break;
		end
		axi_rd(lhb_pkg::OFS_RX, v, r);
		chk(v & 32'h1ffff, exp);
	endtask

	function automatic logic [15:0] spread(input logic [7:0] b);
		spread = 16'haaaa;
		for (int i = 0; i < 8; i++)
			spread[2 * i] = b[i];
	endfunction

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_modes();
		logic [1:0]  sb [8] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
		logic [1:0]  ss [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
		logic [7:0]  sm [8] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h01};
		logic [31:0] v;
		logic [1:0]  r;
		for (int i = 0; i < 8; i++) begin
			rst(sb[i], ss[i], i[0], i[1]);
			axi_rd(lhb_pkg::OFS_STAT, v, r);
			chk(v & 32'h3ff, {22'h0, i[1], i[0], sm[i]});
		end
	endtask

	task automatic t_par16();
		logic [15:0] q;
		for (int m = 2; m < 4; m++) begin
			rst(m[1:0], 2'h0, 1'b1, 1'b0);
			host.par(1'b0, 1'b0, 16'ha5c3, q);
			get_rx(32'h0a5c3);
			host.par(1'b0, 1'b1, 16'h3c5a, q);
			get_rx(32'h13c5a);
			axi_wr(lhb_pkg::OFS_RB, 32'h0000beef);
			host.par(1'b1, 1'b1, 16'h0, q);
			chk({16'h0, q}, 32'hbeef);
			host.par(1'b1, 1'b0, 16'h0, q);
			chk({16'h0, q}, 32'hbeeb);
		end
	endtask

	task automatic t_par8();
		logic [15:0] q;
		rst(2'h0, 2'h0, 1'b0, 1'b1);
		host.par(1'b0, 1'b1, spread(8'h34), q);
		host.par(1'b0, 1'b1, spread(8'h12), q);
		get_rx(32'h11234);
		host.par(1'b0, 1'b0, spread(8'h96), q);
		get_rx(32'h00096);
		rst(2'h1, 2'h0, 1'b1, 1'b0);
		host.par(1'b0, 1'b1, 16'hff78, q);
		host.par(1'b0, 1'b1, 16'h0056, q);
		get_rx(32'h15678);
	endtask

	task automatic t_ser();
		logic [31:0] v;
		logic [1:0]  r;
		rst(2'h0, 2'h2, 1'b0, 1'b0);
		host.ser(8, 9'h0a5, 1'b1);
		get_rx(32'h100a5);
		rst(2'h1, 2'h2, 1'b0, 1'b0);
		host.ser(9, 9'h13c, 1'b0);
		get_rx(32'h1003c);
		host.ser(9, 9'h05a, 1'b0);
		get_rx(32'h0005a);
		axi_rd(8'h10, v, r);
		chk({30'h0, r}, {30'h0, lhb_pkg::RESP_SLVERR});
		axi_wr(8'h10, 32'h0);
		chk({30'h0, wresp}, {30'h0, lhb_pkg::RESP_SLVERR});
		// second token lands on an unread word: overrun, then w1c clear
		host.ser(9, 9'h011, 1'b0);
		host.ser(9, 9'h022, 1'b0);
		get_rx(32'h00022);
		axi_rd(lhb_pkg::OFS_STAT, v, r);
		chk({31'h0, v[lhb_pkg::STAT_OVR]}, 32'h1);
		axi_wr(lhb_pkg::OFS_STAT, 32'h00000800);
		axi_rd(lhb_pkg::OFS_STAT, v, r);
		chk({31'h0, v[lhb_pkg::STAT_OVR]}, 32'h0);
		// disabled port must ignore a whole token
		axi_wr(lhb_pkg::OFS_CTRL, 32'h0);
		chk({30'h0, wresp}, {30'h0, lhb_pkg::RESP_OKAY});
		axi_rd(lhb_pkg::OFS_CTRL, v, r);
		chk(v, 32'h0);
		host.ser(9, 9'h033, 1'b0);
		axi_rd(lhb_pkg::OFS_STAT, v, r);
		chk({31'h0, v[lhb_pkg::STAT_RXV]}, 32'h0);
		axi_wr(lhb_pkg::OFS_CTRL, 32'h1);
	endtask

	initial begin
		t_modes();
		t_par16();
		t_par8();
		t_ser();
		close_out();
	end
endmodule

// ==== verilog/lhb_host_port.sv ====
/*
 * lhb_host_port: host bus front end of a dot-matrix display module.
 * Decodes the strapped bus mode, takes parallel or serial transfers
 * from the host on the link clock, hands words to the system side and
 * answers host reads. Software sees it over AXI4-Lite on clk_sys_i.
 * Assumes the link clock runs free and is much faster than host strobes.
 */
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Overview of operation
// RULE1: straps 11/10 pick 6800/8080 16-bit; 01/00 with high lines 0x pick 8-bit.
// RULE2: straps 00 run 8-bit serial; high lines 10 conventional, 11 compact.
// RULE3: straps 01 with high lines 10 run 3-wire serial with 9-bit tokens.
// RULE4: 8-bit parallel takes even lines when lane strap low, lines 0..7 when high.
// RULE5: get-status readback carries both identification strap levels as 2-bit field.
// RULE6: command/data pin low marks a command transfer, high a display data transfer.
// RULE7: 9-bit serial ignores command/data pin; host ties it low.
// RULE8: parallel read/write pins mean direction+enable (6800) or two strobes (8080).
// RULE9: serial modes ignore both read/write pins; host ties them low.
// RULE10: serial clock on data line 0, serial data on data line 8.
// RULE11: 8-bit parallel display word moves as two bytes, low byte first.
// RULE12: host holds reset low at least 3 microseconds.
// RULE13: host waits at least 10 milliseconds after reset before any strobe.
module lhb_host_port (
	// clocks and reset
	input  wire logic        clk_sys_i,
	input  wire logic        clk_link_i,
	input  wire logic        arst_n_i,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// straps
	input  wire logic [1:0]  bus_mode_straps_i,
	input  wire logic        byte_lane_strap_i,
	input  wire logic        production_strap_i,
	// host bus pins
	input  wire logic        chip_select_n_i,
	input  wire logic        cmd_data_select_i,
	input  wire logic        rw_ctrl_hi_i,
	input  wire logic        rw_ctrl_lo_i,
	input  wire logic [15:0] data_line_i,
	output logic [15:0]      data_line_o,
	output logic             data_line_oe_n_o
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [lhb_pkg::PW-1:0] s1;
		logic [lhb_pkg::PW-1:0] s2;
		logic                   en1;
		logic                   en2;
		logic                   rb1;
		logic                   rb2;
		logic                   rb3;
		logic                   ak1;
		logic                   ak2;
		logic [1:0]             cap_p;
		logic                   cap;
		lhb_pkg::lhb_mode_e     mode;
		logic                   lane;
		logic                   prod;
		logic                   act_p;
		logic                   rd;
		logic                   rd_cd;
		logic                   sck_p;
		logic [3:0]             bits;
		logic [8:0]             sh;
		logic                   phase;
		logic [7:0]             lo_byte;
		logic                   xt;
		logic [16:0]            xw;
		logic                   drop;
		logic [15:0]            rbw;
		logic [15:0]            dout;
		logic                   oe_n;
	} lhb_lnk_s;

	typedef struct packed {
		logic        awr;
		logic        wr;
		logic        awg;
		logic        wg;
		logic [7:0]  awa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bv;
		logic [1:0]  br;
		logic        arr;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
		logic        en;
		logic [15:0] rbw;
		logic        rbt;
		logic        rk1;
		logic        rk2;
		logic        x1;
		logic        x2;
		logic        xp;
		logic [16:0] rxw;
		logic        rxv;
		logic        ovr;
		logic [10:0] st1;
		logic [10:0] st2;
	} lhb_sys_s;

	lhb_lnk_s lq;
	lhb_lnk_s ln;
	lhb_sys_s sq;
	lhb_sys_s sn;

	function automatic lhb_pkg::lhb_mode_e mode_of(input logic [1:0] bm, input logic [1:0] hi);
		case (bm)
			2'b11:   mode_of = lhb_pkg::MODE_68_16;
			2'b10:   mode_of = lhb_pkg::MODE_80_16;
			2'b01:   mode_of = !hi[1] ? lhb_pkg::MODE_68_8 :
				(hi[0] ? lhb_pkg::MODE_NONE : lhb_pkg::MODE_S9);
			default: mode_of = !hi[1] ? lhb_pkg::MODE_80_8 :
				(hi[0] ? lhb_pkg::MODE_S8U : lhb_pkg::MODE_S8C);
		endcase
	endfunction

	function automatic logic [7:0] evens(input logic [15:0] d);
		evens = {d[14], d[12], d[10], d[8], d[6], d[4], d[2], d[0]};
	endfunction

	function automatic logic [15:0] spread(input logic [7:0] b, input logic lane);
		spread = lane ? {8'h00, b} : {1'b0, b[7], 1'b0, b[6], 1'b0, b[5], 1'b0, b[4],
			1'b0, b[3], 1'b0, b[2], 1'b0, b[1], 1'b0, b[0]};
	endfunction

	// ---------------------------------------------------------------
	// link domain
	// ---------------------------------------------------------------
	logic m68, m80, m8, ser;
	assign m68 = (lq.mode == lhb_pkg::MODE_68_16) || (lq.mode == lhb_pkg::MODE_68_8);
	assign m80 = (lq.mode == lhb_pkg::MODE_80_16) || (lq.mode == lhb_pkg::MODE_80_8);
	assign m8  = (lq.mode == lhb_pkg::MODE_68_8) || (lq.mode == lhb_pkg::MODE_80_8);
	assign ser = (lq.mode == lhb_pkg::MODE_S8C) || (lq.mode == lhb_pkg::MODE_S8U) ||
		(lq.mode == lhb_pkg::MODE_S9);

	always_comb begin
		logic        csn;
		logic        act;
		logic        emit;
		logic [7:0]  bsel;
		logic [15:0] d;
		logic [15:0] w16;
		logic [8:0]  tok;
		logic [16:0] ew;
		ln = lq;
		d = lq.s2[15:0];
		csn = lq.s2[lhb_pkg::P_CSN] || !lq.en2;
		// 6800: hi is enable, lo is direction; 8080: both are low strobes
		act = !csn && (m68 ? lq.s2[lhb_pkg::P_HI] :
			(m80 && (!lq.s2[lhb_pkg::P_HI] || !lq.s2[lhb_pkg::P_LO]))); // [RULE8] [RULE9]
		bsel = lq.lane ? d[7:0] : evens(d); // [RULE4]
		w16 = lq.rbw;
		tok = {lq.sh[7:0], d[lhb_pkg::SDA_LINE]}; // [RULE10]
		emit = 1'b0;
		ew = '0;
		ln.s1 = {bus_mode_straps_i, byte_lane_strap_i, production_strap_i, chip_select_n_i,
			rw_ctrl_hi_i, rw_ctrl_lo_i, cmd_data_select_i, data_line_i};
		ln.s2 = lq.s1;
		ln.en1 = sq.en;
		ln.en2 = lq.en1;
		ln.rb1 = sq.rbt;
		ln.rb2 = lq.rb1;
		ln.rb3 = lq.rb2;
		ln.ak1 = sq.xp;
		ln.ak2 = lq.ak1;
		// readback word is held still by the system side until rb3 echoes
		if (lq.rb3 != lq.rb2)
			ln.rbw = sq.rbw;
		// straps are read once, two cycles after reset so s2 holds real pins
		ln.cap_p = {lq.cap_p[0], 1'b1};
		if (lq.cap_p[1] && !lq.cap) begin
			ln.cap = 1'b1;
			ln.mode = mode_of(lq.s2[lhb_pkg::P_BM +: 2],
				{d[lhb_pkg::HI15], d[lhb_pkg::HI13]}); // [RULE1] [RULE2] [RULE3]
			ln.lane = lq.s2[lhb_pkg::P_LANE];
			ln.prod = lq.s2[lhb_pkg::P_PROD];
		end
		// parallel strobe start: reads drive the bus right away
		ln.act_p = act;
		if (act && !lq.act_p) begin
			ln.rd = m68 ? lq.s2[lhb_pkg::P_LO] : !lq.s2[lhb_pkg::P_HI]; // [RULE8]
			ln.rd_cd = lq.s2[lhb_pkg::P_CD];
			if (ln.rd) begin
				if (!lq.s2[lhb_pkg::P_CD])
					w16[lhb_pkg::PID_LSB +: 2] = {lq.lane, lq.prod}; // [RULE5] [RULE6]
				ln.oe_n = 1'b0;
				ln.dout = !m8 ? w16 : spread((lq.phase && lq.s2[lhb_pkg::P_CD]) ?
					w16[15:8] : w16[7:0], lq.lane); // [RULE4] [RULE11]
			end
		end
		// parallel strobe end: writes are taken here
		if (!act && lq.act_p) begin
			ln.oe_n = 1'b1;
			if (lq.rd)
				ln.phase = lq.rd_cd && m8 && !lq.phase; // [RULE11]
			else if (!m8) begin
				emit = 1'b1;
				ew = {lq.s2[lhb_pkg::P_CD], d}; // [RULE6]
			end else if (!lq.s2[lhb_pkg::P_CD]) begin
				emit = 1'b1;
				ew = {1'b0, 8'h00, bsel};
				ln.phase = 1'b0;
			end else if (!lq.phase) begin
				ln.lo_byte = bsel; // [RULE11]
				ln.phase = 1'b1;
			end else begin
				emit = 1'b1;
				ew = {1'b1, bsel, lq.lo_byte}; // [RULE11]
				ln.phase = 1'b0;
			end
		end
		// serial: shift on sck rise, msb first; rw pins never looked at
		ln.sck_p = d[lhb_pkg::SCK_LINE];
		if (!ser || csn)
			ln.bits = 4'h0;
		else if (d[lhb_pkg::SCK_LINE] && !lq.sck_p) begin // [RULE10]
			ln.sh = tok;
			ln.bits = lq.bits + 4'h1;
			if (ln.bits == ((lq.mode == lhb_pkg::MODE_S9) ? lhb_pkg::TOK9 : lhb_pkg::TOK8)) begin
				emit = 1'b1;
				ln.bits = 4'h0;
				if (lq.mode == lhb_pkg::MODE_S9)
					ew = {tok[8], 8'h00, tok[7:0]}; // [RULE7]
				else
					ew = {lq.s2[lhb_pkg::P_CD], 8'h00, tok[7:0]}; // [RULE2] [RULE6]
			end
		end
		// no buffer: a word arriving before the last one was acked is lost
		if (emit) begin
			if (lq.xt != lq.ak2)
				ln.drop = 1'b1;
			else begin
				ln.xw = ew;
				ln.xt = !lq.xt;
			end
		end
	end

	always_ff @(posedge clk_link_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lq <= '0;
			lq.mode <= lhb_pkg::MODE_NONE;
			lq.oe_n <= 1'b1;
		end else begin
			lq <= ln;
		end
	end

	// ---------------------------------------------------------------
	// system domain and register bus
	// ---------------------------------------------------------------
	always_comb begin
		logic [31:0] stat;
		logic        rbb;
		sn = sq;
		rbb = sq.rbt != sq.rk2;
		stat = '0;
		stat[7:0] = sq.st2[7:0];
		stat[lhb_pkg::STAT_LANE] = sq.st2[8];
		stat[lhb_pkg::STAT_PROD] = sq.st2[9];
		stat[lhb_pkg::STAT_DROP] = sq.st2[10];
		stat[lhb_pkg::STAT_RXV] = sq.rxv;
		stat[lhb_pkg::STAT_OVR] = sq.ovr;
		stat[lhb_pkg::STAT_RBB] = rbb;
		sn.st1 = {lq.drop, lq.prod, lq.lane, lq.mode};
		sn.st2 = sq.st1;
		sn.x1 = lq.xt;
		sn.x2 = sq.x1;
		sn.rk1 = lq.rb3;
		sn.rk2 = sq.rk1;
		if (s_axi_awvalid_i && sq.awr) begin
			sn.awr = 1'b0;
			sn.awg = 1'b1;
			sn.awa = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && sq.wr) begin
			sn.wr = 1'b0;
			sn.wg = 1'b1;
			sn.wd = s_axi_wdata_i;
			sn.ws = s_axi_wstrb_i;
		end
		if (sq.awg && sq.wg && !sq.bv) begin
			sn.awg = 1'b0;
			sn.wg = 1'b0;
			sn.bv = 1'b1;
			sn.br = lhb_pkg::RESP_OKAY;
			case ({sq.awa[7:2], 2'b00})
				lhb_pkg::OFS_CTRL: if (sq.ws[0]) sn.en = sq.wd[lhb_pkg::CTRL_EN];
				lhb_pkg::OFS_STAT: if (sq.ws[1] && sq.wd[lhb_pkg::STAT_OVR]) sn.ovr = 1'b0;
				lhb_pkg::OFS_RX:   sn.br = lhb_pkg::RESP_OKAY;
				lhb_pkg::OFS_RB: begin
					// held while the link still copies the previous word
					if (!rbb) begin
						sn.rbw = {sq.ws[1] ? sq.wd[15:8] : sq.rbw[15:8],
							sq.ws[0] ? sq.wd[7:0] : sq.rbw[7:0]};
						sn.rbt = !sq.rbt;
					end
				end
				default: sn.br = lhb_pkg::RESP_SLVERR;
			endcase
		end
		if (sq.bv && s_axi_bready_i) begin
			sn.bv = 1'b0;
			sn.awr = 1'b1;
			sn.wr = 1'b1;
		end
		if (s_axi_arvalid_i && sq.arr) begin
			sn.arr = 1'b0;
			sn.rv = 1'b1;
			sn.rr = lhb_pkg::RESP_OKAY;
			sn.rd = '0;
			case ({s_axi_araddr_i[7:2], 2'b00})
				lhb_pkg::OFS_CTRL: sn.rd[lhb_pkg::CTRL_EN] = sq.en;
				lhb_pkg::OFS_STAT: sn.rd = stat;
				lhb_pkg::OFS_RX: begin
					sn.rd[16:0] = sq.rxw;
					sn.rxv = 1'b0;
				end
				lhb_pkg::OFS_RB:   sn.rd[15:0] = sq.rbw;
				default:           sn.rr = lhb_pkg::RESP_SLVERR;
			endcase
		end
		if (sq.rv && s_axi_rready_i) begin
			sn.rv = 1'b0;
			sn.arr = 1'b1;
		end
		// new word last, so it wins over a clear by read in the same cycle
		if (sq.x2 != sq.xp) begin
			sn.xp = sq.x2;
			sn.rxw = lq.xw;
			if (sn.rxv)
				sn.ovr = 1'b1;
			sn.rxv = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sq <= '0;
			sq.awr <= 1'b1;
			sq.wr <= 1'b1;
			sq.arr <= 1'b1;
			sq.en <= lhb_pkg::CTRL_EN_RST;
		end else begin
			sq <= sn;
		end
	end

	assign s_axi_awready_o  = sq.awr;
	assign s_axi_wready_o   = sq.wr;
	assign s_axi_bvalid_o   = sq.bv;
	assign s_axi_bresp_o    = sq.br;
	assign s_axi_arready_o  = sq.arr;
	assign s_axi_rvalid_o   = sq.rv;
	assign s_axi_rdata_o    = sq.rd;
	assign s_axi_rresp_o    = sq.rr;
	assign data_line_o      = lq.dout;
	assign data_line_oe_n_o = lq.oe_n;

	// ---------------------------------------------------------------
	// checks, link domain
	// ---------------------------------------------------------------
	logic [1:0] chk_bm;
	logic [1:0] chk_hi;
	assign chk_bm = lq.s2[lhb_pkg::P_BM +: 2];
	assign chk_hi = {lq.s2[lhb_pkg::HI15], lq.s2[lhb_pkg::HI13]};

	default clocking cb @(posedge clk_link_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_rd80;
		m80 && lq.s2[lhb_pkg::P_HI] && lq.s2[lhb_pkg::P_LO] ##1
		m80 && !lq.s2[lhb_pkg::P_HI] && !lq.s2[lhb_pkg::P_CSN] && lq.en2;
	endsequence

	a_mode_par16: assert property ($rose(lq.cap) && $past(chk_bm) == 2'b11 |-> // [RULE1]
		lq.mode == lhb_pkg::MODE_68_16) else $error("6800 16-bit mode not chosen");
	a_mode_hold: assert property (lq.cap |=> $stable(lq.mode)) // [RULE1]
		else $error("bus mode changed after capture");
	a_mode_s8u: assert property ($rose(lq.cap) && $past(chk_bm) == 2'b00 && // [RULE2]
		$past(chk_hi) == 2'b11 |-> lq.mode == lhb_pkg::MODE_S8U)
		else $error("compact serial mode not chosen");
	a_mode_s9: assert property ($rose(lq.cap) && $past(chk_bm) == 2'b01 && // [RULE3]
		$past(chk_hi) == 2'b10 |-> lq.mode == lhb_pkg::MODE_S9)
		else $error("9-bit serial mode not chosen");
	a_lane_pick: assert property (m8 && lq.lane && $rose(lq.phase) && !lq.rd |-> // [RULE4]
		lq.lo_byte == $past(lq.s2[7:0])) else $error("wrong byte lane taken");
	a_pid_field: assert property (!m8 && $fell(lq.oe_n) && !lq.rd_cd |-> // [RULE5]
		lq.dout[lhb_pkg::PID_LSB +: 2] == {lq.lane, lq.prod})
		else $error("strap field missing from status read");
	a_cd_par16: assert property (!m8 && !ser && $changed(lq.xt) |-> // [RULE6]
		lq.xw[16] == $past(lq.s2[lhb_pkg::P_CD])) else $error("command/data flag lost");
	a_cd_s9: assert property (lq.mode == lhb_pkg::MODE_S9 && $changed(lq.xt) |-> // [RULE7]
		lq.xw[16] == $past(lq.sh[7])) else $error("9-bit token flag not used");
	a_rd80_drive: assert property (s_rd80 |=> !lq.oe_n) // [RULE8]
		else $error("8080 read strobe did not drive bus");
	a_ser_quiet: assert property (ser |-> lq.oe_n) // [RULE9]
		else $error("bus driven in serial mode");
	a_pair_low: assert property (m8 && $changed(lq.xt) && lq.xw[16] |-> // [RULE11]
		lq.xw[7:0] == $past(lq.lo_byte)) else $error("display word bytes misordered");
endmodule

// ==== verilog/lhb_pkg.sv ====
/*
 * lhb_pkg: shared constants for the display host bus port: bus mode
 * codes, register offsets and field positions, pin vector layout.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package lhb_pkg;
	// -------------------------------------------------------------
	// bus modes, one-hot
	// -------------------------------------------------------------
	typedef enum logic [7:0] {
		MODE_NONE  = 8'h01,
		MODE_68_16 = 8'h02,
		MODE_80_16 = 8'h04,
		MODE_68_8  = 8'h08,
		MODE_80_8  = 8'h10,
		MODE_S8C   = 8'h20,
		MODE_S8U   = 8'h40,
		MODE_S9    = 8'h80
	} lhb_mode_e;

	// -------------------------------------------------------------
	// register map (byte addresses)
	// -------------------------------------------------------------
	localparam int unsigned AXI_AW    = 8;
	localparam logic [7:0]  OFS_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_STAT  = 8'h04;
	localparam logic [7:0]  OFS_RX    = 8'h08;
	localparam logic [7:0]  OFS_RB    = 8'h0c;
	localparam int unsigned CTRL_EN   = 0;
	localparam logic        CTRL_EN_RST = 1'b1;
	localparam int unsigned STAT_LANE = 8;
	localparam int unsigned STAT_PROD = 9;
	localparam int unsigned STAT_RXV  = 10;
	localparam int unsigned STAT_OVR  = 11;
	localparam int unsigned STAT_RBB  = 12;
	localparam int unsigned STAT_DROP = 13;
	localparam int unsigned PID_LSB   = 2;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// -------------------------------------------------------------
	// pin vector layout and serial framing
	// -------------------------------------------------------------
	localparam int unsigned PW       = 24;
	localparam int unsigned P_CD     = 16;
	localparam int unsigned P_LO     = 17;
	localparam int unsigned P_HI     = 18;
	localparam int unsigned P_CSN    = 19;
	localparam int unsigned P_PROD   = 20;
	localparam int unsigned P_LANE   = 21;
	localparam int unsigned P_BM     = 22;
	localparam int unsigned SCK_LINE = 0;
	localparam int unsigned SDA_LINE = 8;
	localparam int unsigned HI15     = 15;
	localparam int unsigned HI13     = 13;
	localparam logic [3:0]  TOK8     = 4'h8;
	localparam logic [3:0]  TOK9     = 4'h9;
endpackage
